// [rtl/eeprom_slave.sv]
// two-wire serial eeprom slave protocol engine
//
// Function
// (RL1) idle bus means both lines high
// (RL2) sda falling while scl high is start
// (RL3) sda rising while scl high is stop
// (RL4) one bit per scl pulse, change when low
// (RL5) receiver pulls sda low on ninth pulse
// (RL6) no acknowledge during programming cycle
// (RL7) master nack ends read, release sda
// (RL8) control byte type code must match
// (RL9) chip-select bits must match select pins
// (RL10) last control bit: 1 read, 0 write
// (RL11) two address bytes, high first, 14 bits
// (RL12) byte write stop launches write cycle
// (RL13) protect pin sampled at write stop
// (RL14) protected write acked, nothing stored
// (RL15) after byte write pointer is next address
// (RL16) page bytes buffered, programmed after stop
// (RL17) only low six pointer bits wrap
// (RL18) master keeps page writes within page
// (RL19) master polls with write control byte
// (RL20) current read returns last address plus one
// (RL21) address loaded before repeated start read
// (RL22) master ack sends next sequential byte
// (RL23) pointer wraps from top to zero
// (RL24) write cycle finishes within 5 ms
// (RL25) start mid-byte restarts control byte wait
`timescale 1ns/1ps
module eeprom_slave #(
    parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES,
    parameter int PAGE_BITS    = eeprom_pkg::PAGE_BITS
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic scl,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe_n,
    input  wire logic select_pin_low,
    input  wire logic select_pin_mid,
    input  wire logic select_pin_high,
    input  wire logic write_protect,
    output logic      busy
);
    localparam int AW    = eeprom_pkg::ADDR_W;
    localparam int PAGE  = 1 << PAGE_BITS;
    localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
    // count after the ninth rise, so the ack slot is seen twice
    localparam logic [3:0] ACK_SEEN = eeprom_pkg::BIT_ACK + 4'h1;

    initial begin
        if (PAGE_BITS < 1 || PAGE_BITS > AW || WRITE_CYCLES < 1) begin
            $error("eeprom_slave: unsupported parameters");
        end
    end

    typedef enum logic [2:0] {
        ST_IDLE, ST_CTRL, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA, ST_RDATA, ST_IGNORE
    } phase_e;

    ////////////////////////////////////////////////////////////////////////
    // pin sampling and bus conditions
    logic [5:0] pins_s;
    logic       scl_s;
    logic       sda_s;
    logic       scl_d;
    logic       sda_d;
    logic [2:0] select_s;
    logic       wp_s;

    line_sync #(.W(6)) u_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in ({scl, sda_in, select_pin_high, select_pin_mid, select_pin_low,
                    write_protect}),
        .sync_out (pins_s)
    );
    assign {scl_s, sda_s, select_s, wp_s} = pins_s;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_d <= 1'b1;                                      // [RL1]
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    logic start_cond;
    logic stop_cond;
    logic scl_rise;
    logic scl_fall;
    assign start_cond = scl_s && scl_d && sda_d && !sda_s; // [RL2]
    assign stop_cond  = scl_s && scl_d && !sda_d && sda_s; // [RL3]
    assign scl_rise   = scl_s && !scl_d;                   // [RL4]
    assign scl_fall   = !scl_s && scl_d;

    ////////////////////////////////////////////////////////////////////////
    // storage
    mem_if #(.AW(AW)) mem ();
    eeprom_array #(.AW(AW)) u_array (
        .clk (clk),
        .mem (mem)
    );

    ////////////////////////////////////////////////////////////////////////
    // state
    phase_e          phase;
    logic [3:0]      bit_cnt;
    logic [7:0]      shift;
    logic [AW-1:0]   ptr;
    logic [AW-1:0]   page_base;
    logic [7:0]      page_buf [0:PAGE-1];
    logic [PAGE-1:0] page_valid;
    logic            wrote_data;
    logic            sent_byte;
    logic            is_read;
    logic            master_nack;
    logic [CNT_W-1:0] wr_timer;
    logic            programming;
    logic [PAGE_BITS:0] prog_idx;

    function automatic logic [AW-1:0] page_step(input logic [AW-1:0] a);
        // low bits wrap inside the page, upper bits untouched
        page_step = {a[AW-1:PAGE_BITS], a[PAGE_BITS-1:0] + 1'b1}; // [RL17]
    endfunction

    logic ctrl_match;
    assign ctrl_match = (shift[6:3] == eeprom_pkg::TYPE_CODE) // [RL8]
                        && (shift[2:0] == select_s);           // [RL9]

    logic byte_done;
    assign byte_done = scl_rise && bit_cnt == eeprom_pkg::BIT_LAST;

    ////////////////////////////////////////////////////////////////////////
    // bit counter and shift register; bits taken on scl rise
    always_ff @(posedge clk) begin
        if (sys_rst || start_cond || stop_cond) begin
            bit_cnt <= '0;                                      // [RL25]
        end else if (scl_fall && bit_cnt == ACK_SEEN) begin
            bit_cnt <= '0;
        end else if (scl_rise && phase != ST_IDLE && bit_cnt != ACK_SEEN) begin
            bit_cnt <= bit_cnt + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            shift <= '0;
        end else if (scl_rise && bit_cnt <= eeprom_pkg::BIT_LAST) begin
            shift <= {shift[6:0], sda_s};                       // [RL4]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // protocol phase and address pointer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase      <= ST_IDLE;
            ptr        <= '0;
            page_base  <= '0;
            page_valid <= '0;
            wrote_data <= 1'b0;
            is_read    <= 1'b0;
            master_nack <= 1'b0;
        end else if (start_cond) begin
            phase      <= ST_CTRL;                              // [RL25]
            wrote_data <= 1'b0;                                 // [RL21]
            page_valid <= programming ? page_valid : '0;
            master_nack <= 1'b0;
        end else if (stop_cond) begin
            phase      <= ST_IDLE;                              // [RL3]
            // page_valid must survive into the write cycle; the next start outside a write cycle clears it
            wrote_data <= 1'b0;
        end else if (byte_done) begin
            case (phase)
                ST_CTRL: begin
                    // shift holds bits 7..1, sda_s is direction
                    if (ctrl_match && !programming) begin       // [RL6]
                        is_read <= sda_s;                        // [RL10]
                        phase   <= sda_s ? ST_RDATA : ST_ADDR_HI;
                    end else begin
                        phase <= ST_IGNORE;
                    end
                end
                ST_ADDR_HI: begin
                    ptr[AW-1:8] <= {shift[AW-10:0], sda_s};      // [RL11]
                    phase       <= ST_ADDR_LO;
                end
                ST_ADDR_LO: begin
                    ptr[7:0]  <= {shift[6:0], sda_s};            // [RL21]
                    page_base <= {ptr[AW-1:8], shift[6:0], sda_s};
                    phase     <= ST_WDATA;
                end
                ST_WDATA: begin
                    page_buf[ptr[PAGE_BITS-1:0]]   <= {shift[6:0], sda_s}; // [RL16]
                    page_valid[ptr[PAGE_BITS-1:0]] <= 1'b1;
                    wrote_data <= 1'b1;
                    ptr        <= page_step(ptr);                // [RL15]
                end
                default: begin
                end
            endcase
        end else if (phase == ST_RDATA && scl_rise && bit_cnt == eeprom_pkg::BIT_ACK
                     && sent_byte) begin
            // master ack pulls sda low; nack releases
            master_nack <= sda_s;                               // [RL7]
            ptr         <= ptr + 1'b1;                          // [RL22] [RL23]
        end
    end

    // a read starting with the pointer; sent byte is latched at byte start
    assign mem.rd_addr = ptr;                                   // [RL20]

    ////////////////////////////////////////////////////////////////////////
    // acknowledge and read data drive
    logic [7:0] tx_byte;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sent_byte <= 1'b0;
            tx_byte   <= '0;
            sda_out   <= 1'b1;
            sda_oe_n  <= 1'b1;
        end else if (start_cond || stop_cond) begin
            sent_byte <= 1'b0;
            sda_oe_n  <= 1'b1;
        end else if (scl_fall) begin
            sda_out  <= 1'b0;
            sda_oe_n <= 1'b1;
            if (bit_cnt == eeprom_pkg::BIT_ACK) begin
                // ninth pulse: ack what we addressed or received
                if (phase == ST_ADDR_HI || phase == ST_ADDR_LO || phase == ST_WDATA
                    || (phase == ST_RDATA && !sent_byte)) begin
                    sda_oe_n <= 1'b0;                           // [RL5] [RL14]
                end
            end else if (phase == ST_RDATA && !master_nack && bit_cnt == ACK_SEEN) begin
                // first data bit goes out now, rest on later falls
                tx_byte   <= {mem.rd_data[6:0], 1'b0};
                sda_oe_n  <= mem.rd_data[7];                    // [RL22]
                sent_byte <= 1'b1;
            end else if (phase == ST_RDATA && sent_byte
                         && bit_cnt <= eeprom_pkg::BIT_LAST && bit_cnt != 4'h0) begin
                tx_byte  <= {tx_byte[6:0], 1'b0};
                sda_oe_n <= tx_byte[7];                          // [RL7]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // self-timed write cycle
    logic launch;
    assign launch = stop_cond && wrote_data && !programming && !wp_s; // [RL12] [RL13]

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            programming <= 1'b0;
            wr_timer    <= '0;
            prog_idx    <= '0;
        end else if (launch) begin
            programming <= 1'b1;                                // [RL24]
            wr_timer    <= CNT_W'(WRITE_CYCLES - 1);
            prog_idx    <= '0;
        end else if (programming) begin
            // array update is spread over the first cycles of the timer
            if (prog_idx != (PAGE_BITS+1)'(PAGE)) begin
                prog_idx <= prog_idx + 1'b1;                    // [RL16]
            end
            if (wr_timer == '0) begin
                programming <= 1'b0;
            end else begin
                wr_timer <= wr_timer - 1'b1;
            end
        end
    end

    assign mem.wr_en   = programming && prog_idx != (PAGE_BITS+1)'(PAGE)
                         && page_valid[prog_idx[PAGE_BITS-1:0]];
    assign mem.wr_addr = {page_base[AW-1:PAGE_BITS], prog_idx[PAGE_BITS-1:0]};
    assign mem.wr_data = page_buf[prog_idx[PAGE_BITS-1:0]];

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy <= 1'b0;
        end else begin
            busy <= launch || (programming && wr_timer != '0);  // [RL6]
        end
    end
endmodule // eeprom_slave

// [include/eeprom_pkg.sv]
// package: constants for the two-wire eeprom slave engine
package eeprom_pkg;
    localparam int          ADDR_W        = 14;
    localparam int          PAGE_BITS     = 6;
    localparam logic [3:0]  TYPE_CODE     = 4'h6;   // device type code, arbitrary value
    localparam int          CLK_MHZ       = 100;
    localparam int          WRITE_TIME_MS = 5;
    localparam int          WRITE_CYCLES  = WRITE_TIME_MS * 1000 * CLK_MHZ;
    localparam logic [3:0]  BIT_LAST      = 4'h7;
    localparam logic [3:0]  BIT_ACK       = 4'h8;
endpackage

// [include/mem_if.sv]
// interface: array access between protocol engine and storage
`timescale 1ns/1ps
interface mem_if #(parameter int AW = 14);
    logic [AW-1:0] rd_addr;
    logic [7:0]    rd_data;
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [7:0]    wr_data;
    modport engine (output rd_addr, output wr_en, output wr_addr, output wr_data,
                    input rd_data);
    modport store  (input rd_addr, input wr_en, input wr_addr, input wr_data,
                    output rd_data);
endinterface

// [rtl/eeprom_array.sv]
// storage array of the eeprom, flip-flops addressed by index
`timescale 1ns/1ps
module eeprom_array #(
    parameter int AW = 14
) (
    input  wire logic clk,
    mem_if.store      mem
);
    logic [7:0] cells [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (mem.wr_en) begin
            cells[mem.wr_addr] <= mem.wr_data;
        end
    end

    assign mem.rd_data = cells[mem.rd_addr];
endmodule // eeprom_array

// [rtl/line_sync.sv]
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module line_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta;

    // idle bus level is high, so reset to ones
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta     <= '1;
            sync_out <= '1;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule // line_sync

// [verification/eeprom_slave_assertions.sv]
// checker: pin-level properties of the eeprom slave
`timescale 1ns/1ps
module eeprom_slave_assertions #(
    parameter int WRITE_CYCLES = 500000
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic select_pin_low,
    input wire logic select_pin_mid,
    input wire logic select_pin_high,
    input wire logic write_protect,
    input wire logic busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    int busy_cnt;
    always_ff @(posedge clk) begin
        busy_cnt <= (sys_rst || !busy) ? 0 : busy_cnt + 1;
    end
    ////////////////////////////////////////
    a_reset_idle: assert property ($fell(sys_rst) |-> sda_oe_n && !busy)
        else $error("outputs not idle after reset");
    a_open_drain: assert property (!sda_oe_n |-> !sda_out)
        else $error("driven level is not low");
    a_busy_silent: assert property (busy |-> sda_oe_n)
        else $error("line driven during write cycle");
    a_busy_bound: assert property (busy_cnt <= WRITE_CYCLES)
        else $error("write cycle too long");
    a_busy_min: assert property ($rose(busy) |-> busy[*8])
        else $error("write cycle collapsed");
    a_busy_after_stop: assert property ($rose(busy) |-> scl && sda_in)
        else $error("write cycle began with bus not idle");
    a_drive_scl_low: assert property ($fell(sda_oe_n) |-> !scl)
        else $error("drive began while clock high");
    a_hold_high: assert property (!sda_oe_n && scl |=> !sda_oe_n || !scl)
        else $error("drive dropped while clock high");
    a_drive_clocked: assert property ($fell(sda_oe_n) |-> ##[1:40] scl)
        else $error("drive not followed by clock pulse");
    c_write_cycle: cover property ($rose(busy));
    c_ack_drive: cover property ($fell(sda_oe_n));
    c_poll_busy: cover property (busy && !scl);
endmodule // eeprom_slave_assertions

// [verification/bus_master_model.sv]
// model: two-wire bus master, clock stands high between frames
`timescale 1ns/1ps
module bus_master_model (
    input  wire logic sda,
    output logic      scl,
    output logic      pull_low
);
    logic [7:0] res;
    event       got;
    initial begin
        scl = 1'b1; // idle means both lines high
        pull_low = 1'b0;
    end
    task automatic wbit(input logic b);
        #40 pull_low = !b; // data moves only with clock low
        #40 scl = 1'b1;
        #80 scl = 1'b0;
    endtask
    task automatic rbit(output logic b);
        #40 pull_low = 1'b0;
        #40 scl = 1'b1;
        #40 b = sda;
        #40 scl = 1'b0;
    endtask
    task automatic start_cond();
        #40 pull_low = 1'b0;
        #40 scl = 1'b1;
        #40 pull_low = 1'b1; // fall under high clock
        #40 scl = 1'b0;
    endtask
    task automatic stop_cond();
        #40 pull_low = 1'b1;
        #40 scl = 1'b1;
        #40 pull_low = 1'b0; // rise under high clock
        #80;
    endtask
    task automatic send_byte(input logic [7:0] b);
        logic a;
        for (int i = 7; i >= 0; i--) wbit(b[i]); // msb first
        rbit(a); // ninth pulse for the acknowledge
        res = {7'h00, a};
        -> got;
    endtask
    task automatic recv_byte(input logic last);
        logic [7:0] b;
        for (int i = 7; i >= 0; i--) rbit(b[i]);
        wbit(last); // release on the last byte
        res = b;
        -> got;
    endtask
endmodule // bus_master_model

// [verification/two_wire_eeprom_slave_test.sv]
// testbench: protocol scenarios for the two-wire eeprom slave
`timescale 1ns/1ps
module two_wire_eeprom_slave_test;
    localparam int WRITE_CYCLES = 200;
    logic        clk;
    logic        sys_rst;
    logic [2:0]  sel;
    logic        write_protect;
    logic        sda_out;
    logic        sda_oe_n;
    logic        busy;
    logic        scl;
    logic        pull_low;
    wire         sda = !(pull_low || !sda_oe_n); // pulled up unless driven
    logic [31:0] lfsr = 32'h000171b6;
    logic [15:0] pg;
    logic [7:0]  v[6];
    logic [7:0]  exp_q[$];
    int          fails = 0;
    int          n_compared = 0;
    eeprom_slave #(.WRITE_CYCLES(WRITE_CYCLES), .PAGE_BITS(eeprom_pkg::PAGE_BITS)) dut (
        .clk(clk), .sys_rst(sys_rst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .select_pin_low(sel[0]), .select_pin_mid(sel[1]),
        .select_pin_high(sel[2]), .write_protect(write_protect), .busy(busy));
    bus_master_model m (.sda(sda), .scl(scl), .pull_low(pull_low));
    initial begin
        clk = 1'b0;
        forever #5 clk = !clk;
    end
    ////////////////////////////////////////
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
    endfunction
    task automatic check(input string name, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(m.got) begin
        if (exp_q.size() == 0) check("unexpected result", 8'hee, m.res);
        else check("bus result", exp_q.pop_front(), m.res);
    end
    task automatic tx(input logic [7:0] b, input logic nack);
        exp_q.push_back({7'h00, nack});
        m.send_byte(b);
    endtask
    task automatic rx(input logic [7:0] d, input logic last);
        exp_q.push_back(d);
        m.recv_byte(last);
    endtask
    task automatic ctrl(input logic rd, input logic ok);
        m.start_cond();
        tx({eeprom_pkg::TYPE_CODE, sel, rd}, !ok);
    endtask
    task automatic point(input logic [15:0] a);
        ctrl(1'b0, 1'b1);
        tx(a[15:8], 1'b0); // high byte first
        tx(a[7:0], 1'b0);
    endtask
    // poll while busy only where a cycle must have started
    task automatic finish_write(input logic exp_busy);
        m.stop_cond();
        @(posedge clk);
        #1;
        check("busy", {7'h00, exp_busy}, {7'h00, busy});
        if (exp_busy) begin
            ctrl(1'b0, 1'b0); // polling refused
            m.stop_cond();
        end
        for (int i = 0; i < 1000 && busy !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        check("busy end", 8'h00, {7'h00, busy});
        if (busy !== 1'b0) complete_run();
        ctrl(1'b0, 1'b1); // accepted again
        m.stop_cond();
    endtask
    ////////////////////////////////////////
    initial begin
        sys_rst = 1'b1;
        write_protect = 1'b0;
        lfsr = step(lfsr);
        sel = lfsr[2:0];
        for (int i = 0; i < 6; i++) begin
            lfsr = step(lfsr);
            v[i] = lfsr[7:0];
        end
        pg = {2'b11, 2'b01, lfsr[13:8], 6'h00}; // top bits set, must be ignored
        repeat (2) @(posedge clk); // sync flops load ones in one clock
        #1 sys_rst = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        m.start_cond();
        tx({eeprom_pkg::TYPE_CODE ^ 4'h3, sel, 1'b0}, 1'b1);
        ctrl(1'b0, 1'b1); // repeated start after ignored byte
        m.stop_cond();
        m.start_cond();
        tx({eeprom_pkg::TYPE_CODE, sel ^ 3'h5, 1'b0}, 1'b1);
        m.stop_cond();
        point(pg + 16'h003f);
        for (int i = 0; i < 3; i++) tx(v[i], 1'b0);
        finish_write(1'b1);
        point(pg + 16'h003e);
        tx(v[3], 1'b0);
        finish_write(1'b1);
        ctrl(1'b1, 1'b1);
        rx(v[0], 1'b1);
        m.stop_cond();
        point(pg);
        ctrl(1'b1, 1'b1);
        rx(v[1], 1'b1);
        m.stop_cond();
        ctrl(1'b1, 1'b1);
        rx(v[2], 1'b1);
        m.stop_cond();
        @(posedge clk);
        #1 write_protect = 1'b1;
        point(pg + 16'h003e);
        tx(v[4], 1'b0);
        finish_write(1'b0);
        #1 write_protect = 1'b0;
        point(pg + 16'h003e);
        ctrl(1'b1, 1'b1);
        rx(v[3], 1'b1);
        m.stop_cond();
        point(16'hffff);
        tx(v[4], 1'b0);
        finish_write(1'b1);
        point(16'h0000);
        tx(v[5], 1'b0);
        finish_write(1'b1);
        point(16'h3fff);
        ctrl(1'b1, 1'b1);
        rx(v[4], 1'b0);
        rx(v[5], 1'b1);
        m.stop_cond();
        m.start_cond();
        for (int i = 0; i < 4; i++) m.wbit(1'b1);
        ctrl(1'b0, 1'b1);
        m.stop_cond();
        repeat (20) @(posedge clk);
        check("pending", 8'h00, 8'(exp_q.size()));
        complete_run();
    end
endmodule // two_wire_eeprom_slave_test
bind eeprom_slave eeprom_slave_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) chk (
    .clk(clk), .sys_rst(sys_rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .select_pin_low(select_pin_low), .select_pin_mid(select_pin_mid),
    .select_pin_high(select_pin_high), .write_protect(write_protect), .busy(busy));
